// ===== inc/amcs_pkg.sv
// Package of constants and types for the converter sequencer
// Functional notes
// R1 - Two independent active-low selects: one for the selector, one for the converter.
// R2 - Selector keeps its latched channel across several conversions without resending.
// R3 - With separate selects, sample throughput can reach 20ksps.
// R4 - Converter powered only while its select is low; high select only shifts command.
// R5 - After conversion, bias and comparator power down; clocks shift LSB-first copy or zeroes.
// R6 - Sample window opens after switch-on delay, closes at second falling clock edge.
// R7 - Second falling edge after select falls starts hold and conversion.
// R8 - Conversion lasts exactly 12 serial clock cycles after hold begins.
// R9 - Sample phase lasts at least one and a half clock cycles.
// R10 - At conversion start the input capacitor switches to the return input.
// R11 - Reference loaded from select fall until end of conversion, else high impedance.
// R12 - Host keeps the serial clock at or below 320kHz.
// R13 - Bits launched on falling clock edge, captured on rising edge, both directions.
// R14 - While select high, rising edges shift input into 4-bit register; last four kept.
// R15 - First stored bit enables a channel; three following bits give channel number.
// R16 - After one null bit, result driven out most significant bit first.
// R17 - Selector select alone updates channel; converter select alone converts current channel.
package amcs_pkg;
    localparam int unsigned CORE_HZ = 20000000;
    localparam int unsigned SWITCH_ON_DELAY_NS = 1000;
    localparam int unsigned SWITCH_ON_CYCLES =
        (SWITCH_ON_DELAY_NS * (CORE_HZ / 1000000) + 999) / 1000;
    localparam int unsigned RESULT_BITS = 12;
    localparam int unsigned CMD_BITS = 4;
    localparam int unsigned CHAN_BITS = 3;
    localparam logic [4:0] CONV_CYCLES = 5'h0c;
    localparam logic [4:0] NULL_BIT_CNT = 5'h01;
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    typedef enum logic [2:0] {
        AMCS_IDLE = 3'b000,
        AMCS_ACQ = 3'b001,
        AMCS_CONV = 3'b011,
        AMCS_MSB = 3'b010,
        AMCS_LSB = 3'b110
    } amcs_phase_t;

    typedef struct packed {
        logic enable;
        logic [CHAN_BITS-1:0] chan;
    } amcs_sel_t;

    typedef struct packed {
        logic sample;
        logic hold;
        logic to_return;
        logic powered;
        logic ref_load;
    } amcs_analog_t;
endpackage : amcs_pkg

// ===== rtl/amcs_sequencer.sv
// Mux and converter sequencer timed by the host serial clock
`timescale 1ns/1ps
`default_nettype none
module amcs_sequencer
    import amcs_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Serial link from host
    input wire logic sclk_i,
    input wire logic selector_chip_select_n_i,
    input wire logic converter_chip_select_n_i,
    input wire logic din_i,
    // Comparator decision from the analog array
    input wire logic comparator_i,
    // Serial data out
    output logic dout_o,
    output logic dout_oe_o,
    // Selector state
    output amcs_sel_t channel_o,
    // Analog controls
    output amcs_analog_t analog_o,
    // Last result
    output logic [RESULT_BITS-1:0] result_o,
    output logic result_valid_o
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] core_rst_sync;
    logic core_rst_n;
    logic [1:0] link_rst_sync;
    logic link_rst_n;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_rst_sync <= 2'h0;
        end else begin
            core_rst_sync <= {core_rst_sync[0], 1'b1};
        end
    end
    assign core_rst_n = core_rst_sync[1];

    always_ff @(posedge sclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link_rst_sync <= 2'h0;
        end else begin
            link_rst_sync <= {link_rst_sync[0], 1'b1};
        end
    end
    assign link_rst_n = link_rst_sync[1];

    // ************************************************************
    // Link domain: rising edge captures, selector command
    // ************************************************************
    typedef struct packed {
        logic [CMD_BITS-1:0] shift;
        amcs_sel_t sel;
        logic sel_cs_q;
        logic sel_tgl;
        logic [RESULT_BITS-1:0] sar;
        logic [RESULT_BITS-1:0] result;
        logic [4:0] bitcnt;
        amcs_phase_t phase;
        logic conv_cs_q;
        logic done_tgl;
    } amcs_rise_t;

    typedef struct packed {
        logic [1:0] falls;
        logic dout;
        logic oe;
        logic hold;
    } amcs_fall_t;

    amcs_rise_t rs;
    amcs_rise_t next_rs;
    amcs_fall_t fs;
    amcs_fall_t next_fs;

    always_comb begin
        next_rs = rs;
        next_rs.sel_cs_q = selector_chip_select_n_i;
        next_rs.conv_cs_q = converter_chip_select_n_i;
        if (selector_chip_select_n_i) begin
            // Keep only the last four bits clocked in  [R14] [R13]
            next_rs.shift = {rs.shift[CMD_BITS-2:0], din_i};
        end else if (rs.sel_cs_q) begin
            // Latch at the first rising edge after select falls; held for later conversions  [R2] [R15] [R17]
            next_rs.sel = amcs_sel_t'(rs.shift);
            next_rs.sel_tgl = ~rs.sel_tgl;
        end
        if (converter_chip_select_n_i) begin
            // Select high resets the sequence  [R4] [R1]
            next_rs.phase = AMCS_IDLE;
            next_rs.bitcnt = 5'h00;
        end else if (!fs.hold) begin
            // Until hold every rising edge keeps the frame acquiring
            next_rs.phase = AMCS_ACQ;
            next_rs.bitcnt = 5'h00;
        end else begin
            unique case (rs.phase)
                AMCS_IDLE, AMCS_ACQ: begin
                    // First decision on the first rising edge of hold  [R8]
                    next_rs.phase = AMCS_CONV;
                    next_rs.sar = RESULT_RESET;
                    next_rs.sar[RESULT_BITS-1] = comparator_i;
                    next_rs.bitcnt = NULL_BIT_CNT;
                end
                AMCS_CONV: begin
                    // One decision per clock, 11 cycles after the first  [R8]
                    next_rs.sar[RESULT_BITS - 1 - rs.bitcnt[3:0]] =
                        comparator_i;
                    next_rs.bitcnt = rs.bitcnt + 5'h01;
                    if (rs.bitcnt == CONV_CYCLES - 5'h01) begin
                        next_rs.phase = AMCS_MSB;
                        next_rs.bitcnt = 5'h00;
                        next_rs.result = next_rs.sar;
                        next_rs.done_tgl = ~rs.done_tgl;
                    end
                end
                AMCS_MSB: begin
                    next_rs.bitcnt = rs.bitcnt + 5'h01;
                    if (rs.bitcnt == CONV_CYCLES - 5'h01) begin
                        next_rs.phase = AMCS_LSB;
                        next_rs.bitcnt = 5'h00;
                    end
                end
                AMCS_LSB: begin
                    if (rs.bitcnt != CONV_CYCLES) begin
                        next_rs.bitcnt = rs.bitcnt + 5'h01;
                    end
                end
                default: begin
                    next_rs.phase = AMCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rs <= '{shift: CMD_RESET, sel: amcs_sel_t'(CMD_RESET),
                    sel_cs_q: 1'b1, sel_tgl: 1'b0, sar: RESULT_RESET,
                    result: RESULT_RESET, bitcnt: 5'h00,
                    phase: AMCS_IDLE, conv_cs_q: 1'b1, done_tgl: 1'b0};
        end else begin
            rs <= next_rs;
        end
    end

    // ************************************************************
    // Link domain: falling edge launches data and hold
    // ************************************************************
    always_comb begin
        next_fs = fs;
        if (converter_chip_select_n_i) begin
            next_fs = '0;
        end else begin
            if (fs.falls != 2'h2) begin
                next_fs.falls = fs.falls + 2'h1;
            end
            // Second falling edge after select falls enters hold  [R7] [R6]
            next_fs.hold = (fs.falls == 2'h1) | fs.hold;
            // Line driven from the null bit on  [R16]
            next_fs.oe = next_fs.hold;
            unique case (rs.phase)
                AMCS_CONV: begin
                    // Null bit before the result  [R16]
                    next_fs.dout = (rs.bitcnt >= NULL_BIT_CNT) ?
                        rs.sar[RESULT_BITS - rs.bitcnt[3:0]] : 1'b0;
                end
                AMCS_MSB: begin
                    next_fs.dout = rs.bitcnt == 5'h00 ?
                        rs.result[0] :
                        rs.result[rs.bitcnt[3:0]];
                end
                AMCS_LSB: begin
                    // Copy is done; only zeroes follow  [R5] [R13]
                    next_fs.dout = 1'b0;
                end
                default: begin
                    next_fs.dout = 1'b0;
                end
            endcase
        end
    end

    always_ff @(negedge sclk_i or negedge link_rst_n
                or posedge converter_chip_select_n_i) begin
        if (!link_rst_n) begin
            fs <= '0;
        end else if (converter_chip_select_n_i) begin
            // Select high ends the frame even with the clock stopped  [R4]
            fs <= '0;
        end else begin
            fs <= next_fs;
        end
    end

    // ************************************************************
    // Core domain: synchronisers and registered outputs
    // ************************************************************
    typedef struct packed {
        logic [1:0] cs_meta;
        logic [1:0] cs;
        logic [2:0] hold_meta;
        logic [2:0] hold;
        logic [2:0] tgl;
        logic [2:0] sel_sync;
        logic [4:0] on_cnt;
        logic dout;
        logic oe;
        amcs_sel_t chan;
        amcs_analog_t ana;
        logic [RESULT_BITS-1:0] result;
        logic valid;
    } amcs_core_t;

    amcs_core_t cs;
    amcs_core_t next_cs;

    always_comb begin
        next_cs = cs;
        next_cs.cs_meta = {selector_chip_select_n_i,
                           converter_chip_select_n_i};
        next_cs.cs = cs.cs_meta;
        // Falling-edge levels cross through two flops  [R16]
        next_cs.hold_meta = {fs.dout, fs.oe, fs.hold};
        next_cs.hold = cs.hold_meta;
        next_cs.tgl = {cs.tgl[1:0], rs.done_tgl};
        next_cs.dout = cs.hold[2];
        next_cs.oe = cs.hold[1];
        // Channel word is stable when its toggle arrives  [R2]
        next_cs.sel_sync = {cs.sel_sync[1:0], rs.sel_tgl};
        if (cs.sel_sync[2] != cs.sel_sync[1]) begin
            next_cs.chan = rs.sel;
        end
        next_cs.valid = 1'b0;
        if (cs.tgl[2] != cs.tgl[1]) begin
            next_cs.result = rs.result;
            next_cs.valid = 1'b1;
        end
        if (cs.cs[0]) begin
            next_cs.on_cnt = 5'h00;
            next_cs.ana = '0;
        end else begin
            if (cs.on_cnt != 5'(SWITCH_ON_CYCLES)) begin
                next_cs.on_cnt = cs.on_cnt + 5'h01;
            end
            // Powered and reference loaded only until result done  [R4] [R11] [R5]
            next_cs.ana.powered = ~cs.ana.to_return | ~next_cs.valid;
            if (next_cs.valid) begin
                next_cs.ana.powered = 1'b0;
                next_cs.ana.ref_load = 1'b0;
            end else if (!cs.ana.hold || cs.ana.powered) begin
                next_cs.ana.ref_load = ~(cs.ana.hold & ~cs.ana.powered);
            end
            // Window after switch-on delay until hold  [R6] [R9] [R3]
            next_cs.ana.sample = (cs.on_cnt == 5'(SWITCH_ON_CYCLES)) &
                                 ~cs.hold[0] & channel_o.enable;
            next_cs.ana.hold = cs.hold[0];
            // Capacitor moves to the return input at hold  [R10]
            next_cs.ana.to_return = cs.hold[0];
            if (cs.ana.hold && !cs.ana.powered) begin
                next_cs.ana.powered = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            cs <= '{cs_meta: 2'h3, cs: 2'h3, hold_meta: 3'h0,
                    hold: 3'h0, tgl: 3'h0, sel_sync: 3'h0,
                    on_cnt: 5'h00, dout: 1'b0,
                    oe: 1'b0, chan: amcs_sel_t'(CMD_RESET), ana: '0,
                    result: RESULT_RESET, valid: 1'b0};
        end else begin
            cs <= next_cs;
        end
    end

    assign dout_o = cs.dout;
    assign dout_oe_o = cs.oe;
    assign channel_o = cs.chan;
    assign analog_o = cs.ana;
    assign result_o = cs.result;
    assign result_valid_o = cs.valid;
endmodule : amcs_sequencer
`default_nettype wire

// ===== verif/amcs_host.sv
// Host model driving the selects, serial clock and command bits
`timescale 1ns/1ps
`default_nettype none
module amcs_host (
    // Core clock and device data
    input wire logic core_clk_i,
    input wire logic dout_i,
    // Link toward the device
    output logic sclk_o,
    output logic sel_n_o,
    output logic cnv_n_o,
    output logic din_o,
    output logic comp_o
);
    // ****
    // Link driver
    // ****
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        cnv_n_o = 1'b1;
        din_o = 1'b0;
        comp_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt
    // Half period of 32 core cycles keeps the link at 312.5kHz
    task automatic tog(input logic lvl);
        wt(32);
        sclk_o <= lvl;
    endtask : tog
    task automatic cmd(input logic [3:0] w);
        for (int i = 3; i >= 0; i--) begin
            tog(1'b0);
            din_o <= w[i];
            tog(1'b1);
        end
    endtask : cmd
    task automatic frame(input logic s, input logic c, input int n,
        input logic [11:0] res, output logic [12:0] cap,
        output logic [11:0] tail);
        cap = 13'h0000;
        tail = 12'h000;
        if (!sclk_o) tog(1'b1);
        wt(16);
        sel_n_o <= !s;
        cnv_n_o <= !c;
        din_o <= !din_o;
        tog(1'b0);
        tog(1'b1);
        tog(1'b0);
        for (int k = 0; k <= n; k++) begin
            comp_o <= res[11 - (k % 12)];
            tog(1'b1);
            cap = {cap[11:0], dout_i};
            tog(1'b0);
        end
        if (n == 12) begin
            for (int m = 0; m < 12; m++) begin
                tog(1'b1);
                tail = {dout_i, tail[11:1]};
                tog(1'b0);
            end
        end
        wt(16);
        sel_n_o <= 1'b1;
        cnv_n_o <= 1'b1;
        comp_o <= !comp_o;
    endtask : frame
endmodule : amcs_host
`default_nettype wire

// ===== verif/amcs_props.sv
// Port timing checker of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module amcs_props
    import amcs_pkg::*;
(
    // Clock, reset and host link
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic sclk_i,
    input wire logic selector_chip_select_n_i,
    input wire logic converter_chip_select_n_i,
    input wire logic din_i,
    input wire logic comparator_i,
    // Design outputs
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire amcs_sel_t channel_o,
    input wire amcs_analog_t analog_o,
    input wire logic [RESULT_BITS-1:0] result_o,
    input wire logic result_valid_o
);
    // ****
    // Checks
    // ****
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_idle;
        converter_chip_select_n_i [*4];
    endsequence
    sequence s_done;
        result_valid_o ##[0:4] (!analog_o.powered && !analog_o.ref_load);
    endsequence
    AST_IDLE_OFF: assert property (
        s_idle |-> !analog_o.powered && !analog_o.ref_load && !dout_oe_o)
        else $error("converter active while its select is high");
    AST_IDLE_NO_SAMPLE: assert property (
        s_idle |-> !analog_o.sample && !analog_o.hold)
        else $error("sample or hold while converter deselected");
    AST_HOLD_EXCL: assert property (
        analog_o.hold |-> !analog_o.sample)
        else $error("sample window open during hold");
    AST_RETURN_AT_HOLD: assert property (
        $rose(analog_o.hold) |-> analog_o.to_return && analog_o.powered)
        else $error("input not on return at conversion start");
    AST_SHUTDOWN: assert property (
        result_valid_o |-> s_done)
        else $error("no power down after conversion");
    AST_VALID_IN_HOLD: assert property (
        result_valid_o |-> analog_o.hold && !converter_chip_select_n_i)
        else $error("result outside a conversion frame");
    AST_VALID_PULSE: assert property (
        result_valid_o |=> !result_valid_o)
        else $error("result valid longer than one cycle");
    AST_CHAN_LATCH: assert property (
        !$stable(channel_o) |-> !selector_chip_select_n_i)
        else $error("channel changed while selector deselected");
    AST_SAMPLE_POWERED: assert property (
        analog_o.sample |-> analog_o.powered && analog_o.ref_load)
        else $error("sampling while unpowered");
    AST_SAMPLE_LATE: assert property (
        $fell(converter_chip_select_n_i) |-> (!analog_o.sample) [*8])
        else $error("sample window before switch-on delay");
endmodule : amcs_props
bind amcs_sequencer amcs_props u_props (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i),
    .selector_chip_select_n_i(selector_chip_select_n_i),
    .converter_chip_select_n_i(converter_chip_select_n_i),
    .din_i(din_i), .comparator_i(comparator_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .channel_o(channel_o), .analog_o(analog_o),
    .result_o(result_o), .result_valid_o(result_valid_o)
);
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    error_cnt++; end end
module tb
    import amcs_pkg::*;
;
    logic clk, arst_n, sclk, sel_n, cnv_n, din, comp, dout, dout_oe, valid;
    amcs_sel_t chan;
    amcs_analog_t ana;
    logic [RESULT_BITS-1:0] res;
    int error_cnt = 0;
    int compares = 0;
    int rcnt = 0;
    int vcnt = 0;
    amcs_sequencer uut (
        .core_clk_i(clk), .arst_n_i(arst_n), .sclk_i(sclk),
        .selector_chip_select_n_i(sel_n), .converter_chip_select_n_i(cnv_n),
        .din_i(din), .comparator_i(comp), .dout_o(dout),
        .dout_oe_o(dout_oe), .channel_o(chan), .analog_o(ana),
        .result_o(res), .result_valid_o(valid)
    );
    amcs_host host (
        .core_clk_i(clk), .dout_i(dout), .sclk_o(sclk), .sel_n_o(sel_n),
        .cnv_n_o(cnv_n), .din_o(din), .comp_o(comp)
    );
    // ****
    // Scenarios
    // ****
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge sclk) rcnt++;
    always @(negedge clk) if (valid === 1'b1) vcnt++;
    task automatic t_select();
        logic [12:0] c;
        logic [11:0] t;
        for (int w = 0; w < 16; w++) begin
            host.cmd(w[3:0]);
            host.frame(1'b1, 1'b0, 0, 12'h000, c, t);
            `CHK("enable", w[3], chan.enable)
            if (w[3]) `CHK("chan", w[2:0], chan.chan)
            `CHK("powered", 1'b0, ana.powered)
        end
    endtask : t_select
    task automatic t_convert(input logic s, input logic [11:0] p);
        logic [12:0] c;
        logic [11:0] t;
        int r0;
        int v0;
        v0 = vcnt;
        fork
            host.frame(s, 1'b1, 12, p, c, t);
            begin
                @(negedge sclk);
                host.wt(16);
                `CHK("sample", 1'b1, ana.sample)
                @(negedge sclk);
                r0 = rcnt;
                host.wt(8);
                `CHK("hold", 5'h0f, ana)
                `CHK("oe", 1'b1, dout_oe)
                wait (valid === 1'b1);
                `CHK("edges", 12, rcnt - r0)
                host.wt(8);
                `CHK("result", p, res)
                `CHK("shutdown", 2'h0, {ana.powered, ana.ref_load})
            end
        join
        `CHK("dout", {1'b0, p}, c)
        `CHK("tail", {1'b0, p[11:1]}, t)
        `CHK("pulses", v0 + 1, vcnt)
    endtask : t_convert
    task automatic t_abort();
        logic [12:0] c;
        logic [11:0] t;
        int v0;
        v0 = vcnt;
        host.frame(1'b0, 1'b1, 4, 12'h0f0, c, t);
        host.wt(8);
        `CHK("abort pulses", v0, vcnt)
        `CHK("abort power", 1'b0, ana.powered)
    endtask : t_abort
    task automatic t_reset();
        logic [12:0] c;
        logic [11:0] t;
        arst_n <= 1'b0;
        host.wt(4);
        `CHK("reset chan", 4'h0, chan)
        `CHK("reset analog", 5'h00, ana)
        `CHK("reset result", 12'h000, res)
        arst_n <= 1'b1;
        host.wt(8);
        host.cmd(4'hd);
        host.cmd(4'hd);
        host.frame(1'b1, 1'b0, 0, 12'h000, c, t);
        `CHK("relatch", 4'hd, chan)
    endtask : t_reset
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        arst_n = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        host.wt(8);
        t_select();
        host.cmd(4'hd);
        t_convert(1'b1, 12'ha5c);
        t_convert(1'b0, 12'h000);
        t_convert(1'b0, 12'hfff);
        `CHK("kept", 4'hd, chan)
        t_abort();
        t_reset();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
